/* File: bench/iqs_queue_properties.sv */
// iqs_queue_properties.sv: status pin timing checks
// assumes: bound into iqs_queue, one clock
`timescale 1ns/1ps
module iqs_chk (
  // watched ports
  input wire i_clk,
  input wire i_rstn,
  input wire o_bus_phase_clock,
  input wire [1:0] o_queue_status,
  input wire o_opcode_valid
);
  wire p = o_bus_phase_clock;
  wire [1:0] s = o_queue_status;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  a_rel_idle: assert property ($rose(i_rstn) |-> s == 2'h0 && !o_opcode_valid)
    else $error("active at release");
  a_first_rise: assert property ($rose(i_rstn) |-> !p ##1 !p)
    else $error("phase early");
  a_high_hold: assert property ($rose(p) |=> p ##1 !p)
    else $error("high phase length");
  a_low_hold: assert property ($fell(p) |=> !p ##1 p)
    else $error("low phase length");
  a_code_stand: assert property ($changed(s) |=> $stable(s))
    else $error("code too short");
  a_code_lead: assert property ($changed(s) |=> $changed(p))
    else $error("code off edge");
  a_fall_code: assert property ($fell(p) |-> $stable(s))
    else $error("start code moved");
  a_start_gap: assert property (o_opcode_valid |=> !o_opcode_valid [*3])
    else $error("starts too close");
endmodule // iqs_chk
bind iqs_queue iqs_chk chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .o_bus_phase_clock(o_bus_phase_clock),
  .o_queue_status(o_queue_status), .o_opcode_valid(o_opcode_valid));

/* File: bench/iqs_queue_tb.sv */
// iqs_queue_tb.sv: directed bench for the queue
// assumes: core/ on the include path
`timescale 1ns/1ps
`include "iqs_defs.vh"
module iqs_queue_tb;
  logic clk = 0, rstn = 0, fv = 0, dn = 0, wi = 0, cw = 0;
  logic [15:0] fd = 16'h0;
  wire ph, ov, ob;
  wire [1:0] qs, st;
  wire [7:0] op;
  int ns, n_mismatch = 0, comparisons = 0, cyc = 0;
  always #2.5 clk = ~clk;
  iqs_queue dut_u (.i_clk(clk), .i_rstn(rstn), .i_fetch_data(fd), .i_fetch_valid(fv), .i_instr_done(dn),
    .i_want_int(wi), .i_consume_word(cw), .o_bus_phase_clock(ph), .o_queue_status(qs), .o_opcode(op),
    .o_opcode_valid(ov), .o_busy(ob));
  iqs_trace tr_u (.i_phase(ph), .i_status(qs), .o_start(st), .o_starts(ns));
  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task feed(input logic [15:0] w);
    @(negedge clk);
    fd = w;
    fv = 1;
    // one pulse per word, a held valid would load it again
    @(negedge clk);
    fv = 0;
    // released bus must not look like held data
    fd = ~w;
  endtask
  task start(input logic i, input logic [1:0] ec, input logic [7:0] eo);
    int k;
    int n0;
    n0 = ns;
    @(negedge clk);
    dn = 1;
    wi = i;
    for (k = 0; k < 40 && !ov; k++)
      @(negedge clk);
    dn = 0;
    wi = 0;
    repeat (8) @(negedge clk);
    chk("starts", 16'(n0 + 1), 16'(ns));
    chk("start code", {14'h0, ec}, {14'h0, st});
    chk("busy", 16'h1, {15'h0, ob});
    if (!i)
      chk("opcode", {8'h0, eo}, {8'h0, op});
  endtask
  task refuse(input string nm, input logic d);
    int n0;
    n0 = ns;
    @(negedge clk);
    dn = d;
    repeat (40) @(negedge clk);
    dn = 0;
    chk(nm, 16'(n0), 16'(ns));
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    chk("reset code", 16'h0, {14'h0, qs});
    rstn = 1;
    feed(16'ha1b2);
    refuse("few bytes", 1);
    feed(16'hc3d4);
    start(0, `IQS_EX_EVEN, 8'ha1);
    feed(16'he5f6);
    refuse("overlap", 0);
    start(0, `IQS_EX_ODD, 8'hb2);
    @(negedge clk);
    cw = 1;
    // held one phase period so a falling phase edge sees it
    repeat (4) @(negedge clk);
    cw = 0;
    feed(16'h0718);
    start(1, `IQS_EX_INT, 8'h0);
    close_out;
  end
endmodule // iqs_queue_tb

/* File: bench/iqs_trace.sv */
// iqs_trace.sv: outside logic tracking the execution starts
// assumes: sees the status pins only
`timescale 1ns/1ps
module iqs_trace (
  // watched pins
  input wire i_phase,
  input wire [1:0] i_status,
  // rebuilt view
  output reg [1:0] o_start = 2'h0,
  output int o_starts = 0
);
  // keeps last real start, idle falls carry none
  always @(negedge i_phase)
  begin
    if (i_status != 2'h0)
    begin
      o_start <= i_status;
      o_starts <= o_starts + 1;
    end
  end
endmodule // iqs_trace

/* File: core/iqs_defs.vh */
// iqs_defs.vh: constants for the instruction queue and its status output
// assumes: included by bare name from core design files
`ifndef IQS_DEFS_VH
`define IQS_DEFS_VH
// movement codes, shown while the bus phase clock is low, captured at its rise
`define IQS_MV_NONE 2'h0
`define IQS_MV_LATCH 2'h1
`define IQS_MV_ADV_BUS 2'h2
`define IQS_MV_ADV_LATCH 2'h3
// execution start codes, shown while the bus phase clock is high, captured at its fall
`define IQS_EX_NONE 2'h0
`define IQS_EX_INT 2'h1
`define IQS_EX_EVEN 2'h2
`define IQS_EX_ODD 2'h3
// queue geometry
`define IQS_WORD_W 16
`define IQS_MIN_BYTES 3
// bus phase clock divider: half period in core clocks
`define IQS_HALF_CYC 4'h2
`endif

/* File: core/iqs_phase.v */
// iqs_phase.v: bus phase clock generator for the queue tracker
// assumes: single core clock, asynchronous active low reset
`timescale 1ns/1ps
`include "iqs_defs.vh"
module iqs_phase #(
  parameter [3:0] HALF = `IQS_HALF_CYC
)(
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // phase outputs
  output reg o_phase,
  output wire o_rise,
  output wire o_fall
);
  reg [3:0] cnt_q;
  wire wrap;
  assign wrap = (cnt_q == HALF - 4'h1);
  // pulses one core clock before the phase clock edge they name
  assign o_rise = wrap & ~o_phase;
  assign o_fall = wrap & o_phase;
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q <= 4'h0;
      o_phase <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_q <= 4'h0;
      o_phase <= ~o_phase;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // iqs_phase

/* File: core/iqs_queue.v */
// iqs_queue.v: two stage instruction prefetch queue with holding latch
// and time multiplexed two bit queue status output
// assumes: one core clock; fetch data and the core's requests arrive on that clock
//
// What this block does
// - execution only starts when at least three bytes of fetched program are in the queue.
// - a new start is refused until the core signals that the current instruction has finished.
// - the status output carries movement while the phase clock is low and start while it is high.
// - movement codes are 0 none, 1 latch from bus, 2 advance and load bus, 3 advance and load latch.
// - start codes are 0 none, 1 interrupt sequence, 2 even instruction, 3 odd instruction.
// - a movement code seen at a rising edge describes bus data present at the previous falling edge.
// - a start code seen at a falling edge describes the bus cycle starting at that falling edge.
// - the queue is two 16-bit stages with a holding latch feeding the first stage.
// - advancing moves stage one into stage two and loads stage one from the latch or the bus.
// - an even start executes the high byte of stage two, an odd start its low byte.
`timescale 1ns/1ps
`include "iqs_defs.vh"
module iqs_queue #(
  parameter W = `IQS_WORD_W
)(
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // program fetch data bus
  input wire [W-1:0] i_fetch_data,
  input wire i_fetch_valid,
  // core requests
  input wire i_instr_done,
  input wire i_want_int,
  input wire i_consume_word,
  // status pins
  output reg o_bus_phase_clock,
  output reg [1:0] o_queue_status,
  // core view
  output reg [7:0] o_opcode,
  output reg o_opcode_valid,
  output reg o_busy
);
  wire phase;
  wire rise_nxt;
  wire fall_nxt;
  reg [W-1:0] st1_q;
  reg [W-1:0] st2_q;
  reg [W-1:0] lat_q;
  reg st1_v_q;
  reg st2_v_q;
  reg lat_v_q;
  reg odd_q;
  reg [W-1:0] bus_q;
  reg bus_v_q;
  reg [1:0] mv_q;
  reg [1:0] ex_q;
  reg [1:0] mv_d;
  reg [1:0] ex_d;
  reg run_q;

  iqs_phase u_phase (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_phase(phase),
    .o_rise(rise_nxt),
    .o_fall(fall_nxt)
  );

  // bytes available to the core from the second stage onward
  function [2:0] avail_bytes;
    input v2;
    input v1;
    input odd;
    begin
      avail_bytes = (v2 ? (odd ? 3'h1 : 3'h2) : 3'h0) + (v1 ? 3'h2 : 3'h0);
    end
  endfunction

  wire [2:0] avail;
  wire can_adv;
  assign avail = avail_bytes(st2_v_q, st1_v_q, odd_q);
  // room for stage one to shift down: stage two used up or empty
  assign can_adv = st1_v_q & (~st2_v_q | i_consume_word);

  // movement decision, made on the falling phase edge for the data on the bus then
  always @*
  begin
    mv_d = `IQS_MV_NONE;
    if (bus_v_q)
    begin
      if (can_adv | ~st1_v_q)
        mv_d = lat_v_q ? `IQS_MV_ADV_LATCH : `IQS_MV_ADV_BUS;
      else if (!lat_v_q)
        mv_d = `IQS_MV_LATCH;
    end
    else if (lat_v_q & (can_adv | ~st1_v_q))
      mv_d = `IQS_MV_ADV_LATCH;
  end

  // start decision for the bus cycle that begins at this falling edge
  always @*
  begin
    ex_d = `IQS_EX_NONE;
    if (~run_q | i_instr_done)
    begin
      if (avail >= `IQS_MIN_BYTES)
      begin
        if (i_want_int)
          ex_d = `IQS_EX_INT;
        else
          ex_d = odd_q ? `IQS_EX_ODD : `IQS_EX_EVEN;
      end
    end
  end

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st1_q <= {W{1'b0}};
      st2_q <= {W{1'b0}};
      lat_q <= {W{1'b0}};
      bus_q <= {W{1'b0}};
      st1_v_q <= 1'b0;
      st2_v_q <= 1'b0;
      lat_v_q <= 1'b0;
      bus_v_q <= 1'b0;
      odd_q <= 1'b0;
      mv_q <= `IQS_MV_NONE;
      ex_q <= `IQS_EX_NONE;
      run_q <= 1'b0;
      o_bus_phase_clock <= 1'b0;
      o_queue_status <= 2'h0;
      o_opcode <= 8'h00;
      o_opcode_valid <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_bus_phase_clock <= phase;
      o_opcode_valid <= 1'b0;
      if (i_fetch_valid)
      begin
        bus_q <= i_fetch_data;
        bus_v_q <= 1'b1;
      end
      if (fall_nxt)
      begin
        // phase goes low: apply the movement for the data on the bus now
        mv_q <= mv_d;
        ex_q <= ex_d;
        o_queue_status <= ex_d;
        bus_v_q <= i_fetch_valid;
        case (mv_d)
          `IQS_MV_LATCH:
          begin
            lat_q <= bus_q;
            lat_v_q <= 1'b1;
          end
          `IQS_MV_ADV_BUS:
          begin
            st2_q <= st1_q;
            st2_v_q <= st1_v_q;
            st1_q <= bus_q;
            st1_v_q <= 1'b1;
          end
          `IQS_MV_ADV_LATCH:
          begin
            st2_q <= st1_q;
            st2_v_q <= st1_v_q;
            st1_q <= lat_q;
            st1_v_q <= 1'b1;
            lat_q <= bus_q;
            lat_v_q <= bus_v_q;
          end
          default:
          begin
            if (i_consume_word)
              st2_v_q <= 1'b0;
          end
        endcase
        if (ex_d != `IQS_EX_NONE)
        begin
          run_q <= 1'b1;
          o_busy <= 1'b1;
          o_opcode_valid <= 1'b1;
          o_opcode <= odd_q ? st2_q[7:0] : st2_q[W-1:W-8];
          if (ex_d != `IQS_EX_INT)
            odd_q <= ~odd_q;
        end
        else if (i_instr_done)
        begin
          run_q <= 1'b0;
          o_busy <= 1'b0;
        end
      end
      else if (rise_nxt)
      begin
        // phase goes high: show the movement made for the last falling edge
        o_queue_status <= mv_q;
      end
    end
  end
endmodule // iqs_queue
